// File: rtl/bsnv_host.v
/*
  Host controller driving a 128K x 16 byte-select nonvolatile memory
  through its pins; user side is a request/done handshake.
  Assumes the memory pins connect directly and supply_ok comes from a
  supply monitor outside the clock domain.
*/
// Summary of operation
// - Write is write-and-select overlap, address first
// - Address held through whole write
// - Write high for recovery before next
// - Output control high during writes
// - No access until supply good
`timescale 1ns/100ps
`include "bsnv_consts.vh"

module bsnv_host (
  input wire clk,
  input wire nrst,
  input wire supply_ok,
  input wire req,
  input wire req_write,
  input wire [`BSNV_ADDR_W-1:0] req_addr,
  input wire req_upper,
  input wire req_lower,
  input wire [`BSNV_DATA_W-1:0] req_wdata,
  output reg req_ready,
  output reg done,
  output reg [`BSNV_DATA_W-1:0] rdata,
  output reg [`BSNV_ADDR_W-1:0] word_address,
  output reg upper_byte_select_n,
  output reg lower_byte_select_n,
  output reg write_strobe_n,
  output reg output_drive_n,
  input wire [`BSNV_DATA_W-1:0] data_lines_in,
  output reg [`BSNV_DATA_W-1:0] data_lines_out,
  output reg [`BSNV_DATA_W-1:0] data_lines_oe
);
  reg rst_s1_reg;
  reg rst_n_reg;
  reg sup1_reg;
  reg sup2_reg;
  reg sup3_reg;
  reg sup_ok_reg;
  reg [`BSNV_ST_W-1:0] state_reg;
  reg [`BSNV_ST_W-1:0] state_next;
  reg is_write_reg;
  reg upper_reg;
  reg lower_reg;
  reg [`BSNV_DATA_W-1:0] wdata_reg;
  wire [`BSNV_DATA_W-1:0] rd_mask;
  reg tmr_load;
  reg [`BSNV_CNT_W-1:0] tmr_val;
  wire tmr_done;
  wire any_sel;

  localparam [`BSNV_ST_W-1:0] S_IDLE = `BSNV_S_IDLE;
  localparam [`BSNV_ST_W-1:0] S_RSET = `BSNV_S_RSET;
  localparam [`BSNV_ST_W-1:0] S_RACC = `BSNV_S_RACC;
  localparam [`BSNV_ST_W-1:0] S_WFLT = `BSNV_S_WFLT;
  localparam [`BSNV_ST_W-1:0] S_WPUL = `BSNV_S_WPUL;
  localparam [`BSNV_ST_W-1:0] S_WREC = `BSNV_S_WREC;
  // Counts kept 32 bits wide, cut to the timer width where loaded
  localparam [31:0] ACC_N = `BSNV_ACC_CYC;
  localparam [31:0] WP_N = `BSNV_WP_CYC;
  localparam [31:0] REC_N = `BSNV_REC_CYC;

  // Reset release through two flops
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // Supply flag: three flops, change taken once stages two and three agree
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sup1_reg <= 1'b0;
      sup2_reg <= 1'b0;
      sup3_reg <= 1'b0;
      sup_ok_reg <= 1'b0;
    end else begin
      sup1_reg <= supply_ok;
      sup2_reg <= sup1_reg;
      sup3_reg <= sup2_reg;
      if (sup2_reg == sup3_reg) begin
        sup_ok_reg <= sup3_reg;
      end
    end
  end

  bsnv_timer u_timer (
    .clk(clk),
    .rst_n(rst_n_reg),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  assign any_sel = req_upper | req_lower;

  // Byte lane masks from the selects
  genvar gi;
  generate
    for (gi = 0; gi < `BSNV_DATA_W; gi = gi + 1) begin : g_lane
      if (gi >= `BSNV_HI_LSB) begin : g_hi
        assign rd_mask[gi] = upper_reg;
      end else begin : g_lo
        assign rd_mask[gi] = lower_reg;
      end
    end
  endgenerate

  always @* begin
    state_next = state_reg;
    tmr_load = 1'b0;
    tmr_val = {`BSNV_CNT_W{1'b0}};
    case (state_reg)
      S_IDLE: begin
        // Supply must be good before any access
        if (req && any_sel && sup_ok_reg) begin
          state_next = req_write ? S_WFLT : S_RSET;
        end
      end
      S_RSET: begin
        state_next = S_RACC;
        tmr_load = 1'b1;
        tmr_val = ACC_N[`BSNV_CNT_W-1:0];
      end
      S_RACC: begin
        if (tmr_done) begin
          state_next = S_IDLE;
        end
      end
      S_WFLT: begin
        // Address set up a cycle before the pulse
        state_next = S_WPUL;
        tmr_load = 1'b1;
        tmr_val = WP_N[`BSNV_CNT_W-1:0];
      end
      S_WPUL: begin
        if (tmr_done) begin
          state_next = S_WREC;
          tmr_load = 1'b1;
          tmr_val = REC_N[`BSNV_CNT_W-1:0];
        end
      end
      S_WREC: begin
        if (tmr_done) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= S_IDLE;
      is_write_reg <= 1'b0;
      upper_reg <= 1'b0;
      lower_reg <= 1'b0;
      wdata_reg <= {`BSNV_DATA_W{1'b0}};
      req_ready <= 1'b0;
      done <= 1'b0;
      rdata <= {`BSNV_DATA_W{1'b0}};
      word_address <= {`BSNV_ADDR_W{1'b0}};
      upper_byte_select_n <= 1'b1;
      lower_byte_select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_drive_n <= 1'b1;
      data_lines_out <= {`BSNV_DATA_W{1'b0}};
      data_lines_oe <= {`BSNV_DATA_W{1'b0}};
    end else begin
      state_reg <= state_next;
      done <= 1'b0;
      req_ready <= (state_next == S_IDLE) && sup_ok_reg;
      if (state_reg == S_IDLE && state_next != S_IDLE) begin
        is_write_reg <= req_write;
        upper_reg <= req_upper;
        lower_reg <= req_lower;
        wdata_reg <= req_wdata;
        word_address <= req_addr;
      end
      case (state_next)
        S_RSET, S_RACC: begin
          // Read: strobe high, output control and requested selects low
          write_strobe_n <= 1'b1;
          output_drive_n <= 1'b0;
          upper_byte_select_n <= (state_reg == S_IDLE) ? ~req_upper : ~upper_reg;
          lower_byte_select_n <= (state_reg == S_IDLE) ? ~req_lower : ~lower_reg;
        end
        S_WFLT: begin
          output_drive_n <= 1'b1;
          upper_byte_select_n <= 1'b1;
          lower_byte_select_n <= 1'b1;
        end
        S_WPUL: begin
          // Selects and strobe fall together; both rise together
          write_strobe_n <= 1'b0;
          upper_byte_select_n <= ~upper_reg;
          lower_byte_select_n <= ~lower_reg;
          output_drive_n <= 1'b1;
        end
        default: begin
          // Deselected and floating between cycles
          write_strobe_n <= 1'b1;
          output_drive_n <= 1'b1;
          upper_byte_select_n <= 1'b1;
          lower_byte_select_n <= 1'b1;
        end
      endcase
      // Lanes kept driven through recovery: data hold after the selects rise
      if (state_next == S_WPUL || state_next == S_WREC) begin
        data_lines_oe <= rd_mask;
      end else begin
        data_lines_oe <= {`BSNV_DATA_W{1'b0}};
      end
      if (state_reg == S_WFLT) begin
        data_lines_out <= wdata_reg;
      end
      // Sample only selected lanes, others read as zero
      if (state_reg == S_RACC && tmr_done) begin
        rdata <= data_lines_in & rd_mask;
        done <= 1'b1;
      end
      if (state_reg == S_WREC && tmr_done) begin
        done <= 1'b1;
      end
    end
  end
endmodule // bsnv_host

// File: rtl/bsnv_consts.vh
/*
  Constants for the byte-select nonvolatile memory host controller.
  Assumes a 200 MHz system clock and the 70 ns speed grade timing.
*/
`ifndef BSNV_CONSTS_VH
`define BSNV_CONSTS_VH

`define BSNV_CLK_PERIOD_PS 5000
`define BSNV_ADDR_W 17
`define BSNV_DATA_W 16
`define BSNV_BYTE_W 8
`define BSNV_HI_LSB 8
`define BSNV_LO_LSB 0

// Times in ns, as printed for the faster grade
`define BSNV_T_ACCESS_NS 70
`define BSNV_T_WPULSE_NS 55
`define BSNV_T_FLOAT_NS 25
`define BSNV_T_RECOVER_NS 15
`define BSNV_T_HOLD_NS 10

// Least times round up to whole cycles
`define BSNV_CYC(ns) (((ns) * 1000 + `BSNV_CLK_PERIOD_PS - 1) / `BSNV_CLK_PERIOD_PS)
`define BSNV_ACC_CYC (`BSNV_CYC(`BSNV_T_ACCESS_NS) + 1)
`define BSNV_WP_CYC `BSNV_CYC(`BSNV_T_WPULSE_NS)
`define BSNV_FLT_CYC `BSNV_CYC(`BSNV_T_FLOAT_NS)
`define BSNV_REC_CYC `BSNV_CYC(`BSNV_T_RECOVER_NS)
`define BSNV_HLD_CYC `BSNV_CYC(`BSNV_T_HOLD_NS)
`define BSNV_CNT_W 6

// One-hot states
`define BSNV_ST_W 6
`define BSNV_S_IDLE 6'h01
`define BSNV_S_RSET 6'h02
`define BSNV_S_RACC 6'h04
`define BSNV_S_WFLT 6'h08
`define BSNV_S_WPUL 6'h10
`define BSNV_S_WREC 6'h20

`endif

// File: rtl/bsnv_timer.v
/*
  Down counter for the controller's timed phases.
  Assumes load and count come from logic on the same clock.
*/
`timescale 1ns/100ps
`include "bsnv_consts.vh"

module bsnv_timer (
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire [`BSNV_CNT_W-1:0] load_val,
  output wire done
);
  reg [`BSNV_CNT_W-1:0] cnt_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= {`BSNV_CNT_W{1'b0}};
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (cnt_reg != {`BSNV_CNT_W{1'b0}}) begin
      cnt_reg <= cnt_reg - {{(`BSNV_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign done = (cnt_reg == {`BSNV_CNT_W{1'b0}});
endmodule // bsnv_timer

// File: dv/bsnv_mem_model.sv
/* Behavioural model of the 128K x 16 byte-select memory.
   Assumes the host pins connect directly; data_in is the resolved bus. */
`timescale 1ns/100ps
module bsnv_mem_model #(
  parameter ACC_NS = 70
) (
  input wire [16:0] word_address,
  input wire upper_byte_select_n,
  input wire lower_byte_select_n,
  input wire write_strobe_n,
  input wire output_drive_n,
  input wire supply_ok,
  input wire [15:0] data_in,
  output wire [15:0] data_q
);
  logic [15:0] mem [0:131071];
  wire [15:0] lanes = {{8{!upper_byte_select_n}}, {8{!lower_byte_select_n}}};
  wire wr = supply_ok && !write_strobe_n && |lanes;
  wire rd = supply_ok && write_strobe_n && !output_drive_n;
  int chg_n = 0;
  wire [31:0] chg_d;
  // Any change of address, selects or read controls restarts the access time
  always @(word_address or lanes or rd) chg_n++;
  // Inertial delay: only a count left alone for the access time gets through
  assign #(ACC_NS) chg_d = chg_n;
  wire rd_ok = (chg_d === chg_n);
  // Released lanes show the inverse, never the stale value
  assign data_q = mem[word_address] ^ ~(lanes & {16{rd && rd_ok}});
  always @(wr or data_in or word_address or lanes) begin
    if (wr) begin
      mem[word_address] = (mem[word_address] & ~lanes) | (data_in & lanes);
    end
  end
endmodule // bsnv_mem_model

// File: dv/bsnv_host_assertions.sv
/* Pin timing checker for the host controller.
   Bound to bsnv_host; sees its ports only. */
`timescale 1ns/100ps
module bsnv_chk (
  input wire clk,
  input wire nrst,
  input wire done,
  input wire [16:0] word_address,
  input wire upper_byte_select_n,
  input wire lower_byte_select_n,
  input wire write_strobe_n,
  input wire output_drive_n,
  input wire [15:0] data_lines_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ctrl_high_write_a: assert property (!write_strobe_n |-> output_drive_n)
    else $error("output control low in write");
  lane_drive_a: assert property (!write_strobe_n |-> data_lines_oe ==
    {{8{!upper_byte_select_n}}, {8{!lower_byte_select_n}}}) else $error("lane drive wrong");
  addr_hold_a: assert property (!write_strobe_n |-> $stable(word_address))
    else $error("address moved in write");
  pulse_width_a: assert property ($fell(write_strobe_n) |-> ##12 $rose(write_strobe_n))
    else $error("write pulse length");
  sel_end_a: assert property ($rose(write_strobe_n) |->
    upper_byte_select_n && lower_byte_select_n) else $error("select outlasts strobe");
  recover_a: assert property ($rose(write_strobe_n) |->
    (write_strobe_n && upper_byte_select_n && lower_byte_select_n) [*3]) else $error("short recovery");
  read_wait_a: assert property ($fell(output_drive_n) |->
    (!done) [*8] ##1 (!done) [*6] ##[0:6] done) else $error("read sampled early or late");
  read_ctrl_a: assert property (!output_drive_n |-> write_strobe_n &&
    !(upper_byte_select_n && lower_byte_select_n)) else $error("bad read controls");
endmodule // bsnv_chk
bind bsnv_host bsnv_chk chk_u (.clk, .nrst, .done, .word_address, .upper_byte_select_n,
  .lower_byte_select_n, .write_strobe_n, .output_drive_n, .data_lines_oe);

// File: dv/tb_top.sv
/* Self-checking bench for the host controller against the memory model.
   Assumes a 200 MHz clock; lanes resolve from the host's enables. */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic clk = 0, nrst = 0, supply_ok = 0, req = 0, req_write = 0, req_upper = 0, req_lower = 0;
  logic [16:0] req_addr = '0;
  logic [15:0] req_wdata = '0;
  wire req_ready, done, ub_n, lb_n, we_n, oe_n;
  wire [15:0] rdata, d_out, d_oe, mem_q, bus;
  wire [16:0] addr;
  int bad_count = 0, n_checks = 0, cyc = 0;
  assign bus = (d_oe & d_out) | (~d_oe & mem_q);
  initial forever #2.5 clk = ~clk;
  bsnv_host dut_u (.clk(clk), .nrst(nrst), .supply_ok(supply_ok), .req(req),
    .req_write(req_write), .req_addr(req_addr), .req_upper(req_upper), .req_lower(req_lower),
    .req_wdata(req_wdata), .req_ready(req_ready), .done(done), .rdata(rdata),
    .word_address(addr), .upper_byte_select_n(ub_n), .lower_byte_select_n(lb_n),
    .write_strobe_n(we_n), .output_drive_n(oe_n), .data_lines_in(bus),
    .data_lines_out(d_out), .data_lines_oe(d_oe));
  bsnv_mem_model mem_u (.word_address(addr), .upper_byte_select_n(ub_n),
    .lower_byte_select_n(lb_n), .write_strobe_n(we_n), .output_drive_n(oe_n),
    .supply_ok(supply_ok), .data_in(bus), .data_q(mem_q));
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test;
    end
  end
  task acc(input logic w, input logic [16:0] a, input logic u, input logic l,
    input logic [15:0] d, input logic [15:0] e);
    int i;
    i = 0;
    while (req_ready !== 1'b1 && i < 200) begin @(negedge clk); i++; end
    `CHK("ready", 1'b1, req_ready)
    @(posedge clk);
    req <= 1;
    req_write <= w;
    req_addr <= a;
    req_upper <= u;
    req_lower <= l;
    req_wdata <= d;
    @(posedge clk);
    req <= 0;
    i = 0;
    while (done !== 1'b1 && i < 40) begin @(negedge clk); i++; end
    `CHK("done", 1'b1, done)
    if (!w) `CHK("rdata", e, rdata)
  endtask
  task t_power;
    @(posedge clk);
    req <= 1;
    req_upper <= 1;
    repeat (30) begin
      @(negedge clk);
      `CHK("ready", 1'b0, req_ready)
      `CHK("done", 1'b0, done)
    end
    @(posedge clk);
    req <= 0;
    supply_ok <= 1;
    $display("power test done");
  endtask
  task t_word;
    acc(1, 17'h1FFFF, 1, 1, 16'hA5C3, 16'h0000);
    acc(1, 17'h00000, 1, 1, 16'h3C5A, 16'h0000);
    acc(0, 17'h1FFFF, 1, 1, 16'h0000, 16'hA5C3);
    acc(0, 17'h00000, 1, 1, 16'h0000, 16'h3C5A);
    $display("word test done");
  endtask
  task t_lanes;
    acc(1, 17'h1FFFF, 1, 0, 16'h7E00, 16'h0000);
    acc(1, 17'h1FFFF, 0, 1, 16'hFF81, 16'h0000);
    acc(0, 17'h1FFFF, 1, 1, 16'h0000, 16'h7E81);
    acc(0, 17'h1FFFF, 1, 0, 16'h0000, 16'h7E00);
    acc(0, 17'h1FFFF, 0, 1, 16'h0000, 16'h0081);
    $display("lane test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1;
    t_power;
    t_word;
    t_lanes;
    end_of_test;
  end
endmodule // tb_top
